// ==== verilog/sdrc_ctrl.sv ====
// SDRAM command controller driving the memory pins from APB orders
// Summary of operation
// - Stop driving data bus a cycle before first read data is due
// - Burst stop is L,H,H,L and only used with full-page bursts
// - No read, write or precharge to bank during auto-precharge burst
// - No auto-precharge at full page; wait precharge period to reopen
// - After auto-precharge write wait recovery plus precharge period
// - Activate to internal precharge lasts at least minimum active time
// - Precharge is L,L,H,L; autoprecharge bit high closes all banks
// - Reactivate after precharge, waiting at least precharge period
// - Self refresh entry L,L,L,H with gate low, only with banks idle
// - Leave power-down within the refresh period
// - Present no-operation on the edge after raising the clock gate
// - Activate, read, write, mode set, refresh encodings as listed
// - First write beat goes with the command, one beat per edge after
`timescale 1ns/1ps
module sdrc_ctrl #(
  parameter int unsigned REFRESH_LIMIT = sdrc_pkg::REFRESH_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             sd_cs_n,
  output logic             sd_ras_n,
  output logic             sd_cas_n,
  output logic             sd_we_n,
  output logic             sd_cke,
  output logic [1:0]       sd_bank,
  output logic [11:0]      sd_addr,
  output logic [1:0]       sd_dqm,
  output logic [15:0]      sd_dq_out,
  output logic             sd_dq_oe,
  input  wire logic [15:0] sd_dq_in
);
  sdrc_apb_if regs ();

  sdrc_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .regs    (regs)
  );

  sdrc_pkg::sdrc_state_t state_reg, state_next;
  logic [31:0] cmdw_reg, addr_reg, wdata_reg, cfg_reg, rdata_reg;
  logic        go_reg, busy_reg, rd_valid_reg, ap_busy_reg;
  logic [3:0]  cmd_reg;
  logic [1:0]  bank_reg, dqm_reg;
  logic [11:0] sdaddr_reg;
  logic [15:0] dq_reg;
  logic        oe_reg, cke_reg;
  logic [8:0]  beat_reg;
  logic [7:0]  wait_reg;
  logic [31:0] lowp_cnt_reg;
  logic [3:0]  open_reg;
  logic [15:0] d1_reg, d2_reg, d3_reg;

  // Decoded order fields
  wire [2:0]  op       = cmdw_reg[2:0];
  wire        ap_req   = cmdw_reg[sdrc_pkg::CMD_AP_BIT];
  wire        full_pg  = cfg_reg[sdrc_pkg::CFG_LEN_LSB +: 8]
                         == sdrc_pkg::FULL_PAGE_LEN;
  wire [8:0]  burst_len = full_pg ? 9'h100
                          : {1'b0, cfg_reg[sdrc_pkg::CFG_LEN_LSB +: 8]};
  wire [2:0]  lat      = cfg_reg[sdrc_pkg::CFG_LAT_LSB +: 3];
  // Auto-precharge is refused in full-page mode
  wire        ap_ok    = ap_req & ~full_pg;
  wire [1:0]  bank_sel = addr_reg[sdrc_pkg::ADDR_BANK_LSB +: 2];
  wire [7:0]  col      = addr_reg[sdrc_pkg::ADDR_COL_LSB +: 8];
  wire        any_open = |open_reg;
  wire        wr_hit   = regs.wr_stb;
  // Last beat of a short burst is the one with index burst_len - 1
  wire        beats_done = ~full_pg & (beat_reg >= burst_len - 9'h001);
  wire        rd_due   = beat_reg == 9'h000;
  // Read window: burst, latency, and the capture flops behind the pins
  wire [8:0]  rd_span  = (full_pg ? 9'h000 : burst_len) + {6'h00, lat}
                         + 9'(sdrc_pkg::RD_PIPE_CYC);
  wire [7:0]  gap_cyc  = (op == sdrc_pkg::OP_PRE) ?
                         8'(sdrc_pkg::PRE_CYC) :
                         (op == sdrc_pkg::OP_ACT) ?
                         8'(sdrc_pkg::ACTMIN_CYC) :
                         (ap_ok & op == sdrc_pkg::OP_WR) ?
                         8'(sdrc_pkg::DATA_ACT_CYC) :
                         (ap_ok) ? 8'(sdrc_pkg::PRE_CYC + 1) : 8'h01;

  // Read mux for software; status shows controller state
  assign regs.rd_data =
    (regs.rd_addr == sdrc_pkg::REG_CMD)    ? cmdw_reg :
    (regs.rd_addr == sdrc_pkg::REG_ADDR)   ? addr_reg :
    (regs.rd_addr == sdrc_pkg::REG_WDATA)  ? wdata_reg :
    (regs.rd_addr == sdrc_pkg::REG_RDATA)  ? rdata_reg :
    (regs.rd_addr == sdrc_pkg::REG_STATUS) ?
      {24'h000000, ap_busy_reg, open_reg, rd_valid_reg, busy_reg,
       go_reg} :
    (regs.rd_addr == sdrc_pkg::REG_CFG)    ? cfg_reg : 32'h0000_0000;

  // Software register writes; a new order sets go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmdw_reg  <= 32'h0000_0000;
      addr_reg  <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      cfg_reg   <= sdrc_pkg::CFG_RESET;
    end else if (wr_hit) begin
      if (regs.wr_addr == sdrc_pkg::REG_CMD)   cmdw_reg  <= regs.wr_data;
      if (regs.wr_addr == sdrc_pkg::REG_ADDR)  addr_reg  <= regs.wr_data;
      if (regs.wr_addr == sdrc_pkg::REG_WDATA) wdata_reg <= regs.wr_data;
      if (regs.wr_addr == sdrc_pkg::REG_CFG)   cfg_reg   <= regs.wr_data;
    end
  end

  // Order pending flag: a new order beats the engine's taking of the old
  wire take = (state_reg == sdrc_pkg::SDRC_IDLE) & go_reg;
  wire set_go = wr_hit & (regs.wr_addr == sdrc_pkg::REG_CMD)
                & regs.wr_data[sdrc_pkg::CMD_GO_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) go_reg <= 1'b0;
    else          go_reg <= set_go | (go_reg & ~take);
  end

  // Column counter: sequential wraps in block, interleave XORs beat
  wire [7:0] blk_mask = full_pg ? 8'hFF : burst_len[7:0] - 8'h01;
  wire [7:0] seq_col  = (col & ~blk_mask)
                        | ((col + beat_reg[7:0]) & blk_mask);
  wire [7:0] int_col  = col ^ (beat_reg[7:0] & blk_mask);
  wire [7:0] beat_col = cfg_reg[3] ? int_col : seq_col;

  // Main sequencing of commands onto the pins
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sdrc_pkg::SDRC_IDLE:  if (go_reg) state_next = sdrc_pkg::SDRC_ISSUE;
      sdrc_pkg::SDRC_ISSUE: begin
        if (op == sdrc_pkg::OP_WR) state_next = sdrc_pkg::SDRC_WBEAT;
        else if (op == sdrc_pkg::OP_RD) state_next = sdrc_pkg::SDRC_RWAIT;
        else if (op == sdrc_pkg::OP_SELF || op == sdrc_pkg::OP_PDN)
          state_next = sdrc_pkg::SDRC_LOWP;
        else state_next = sdrc_pkg::SDRC_GAP;
      end
      sdrc_pkg::SDRC_WBEAT: if (beats_done | go_reg)
        state_next = sdrc_pkg::SDRC_GAP;
      sdrc_pkg::SDRC_RWAIT: if (rd_due) state_next = sdrc_pkg::SDRC_GAP;
      sdrc_pkg::SDRC_GAP:   if (wait_reg == 8'h00)
        state_next = sdrc_pkg::SDRC_IDLE;
      sdrc_pkg::SDRC_LOWP:  if (cmdw_reg[sdrc_pkg::CMD_EXIT_BIT] |
                                lowp_cnt_reg >= REFRESH_LIMIT - 1)
        state_next = sdrc_pkg::SDRC_WAKE;
      sdrc_pkg::SDRC_WAKE:  state_next = sdrc_pkg::SDRC_GAP;
      default:              state_next = sdrc_pkg::SDRC_IDLE;
    endcase
  end

  // Command to drive in each state
  wire [3:0] order_cmd =
    (op == sdrc_pkg::OP_ACT)  ? sdrc_pkg::CMD_ACT :
    (op == sdrc_pkg::OP_RD)   ? sdrc_pkg::CMD_RD :
    (op == sdrc_pkg::OP_WR)   ? sdrc_pkg::CMD_WR :
    (op == sdrc_pkg::OP_PRE)  ? sdrc_pkg::CMD_PRE :
    (op == sdrc_pkg::OP_BST)  ? (full_pg ? sdrc_pkg::CMD_BST
                                         : sdrc_pkg::CMD_NOP) :
    (op == sdrc_pkg::OP_REF)  ? sdrc_pkg::CMD_REF :
    (op == sdrc_pkg::OP_SELF) ? (any_open ? sdrc_pkg::CMD_NOP
                                          : sdrc_pkg::CMD_REF)
                              : sdrc_pkg::CMD_DESEL;
  // Read, write and precharge orders to any bank are driven as no-operation while auto-precharge is busy
  wire blocked = ap_busy_reg & (op == sdrc_pkg::OP_RD |
                 op == sdrc_pkg::OP_WR | op == sdrc_pkg::OP_PRE);
  wire issuing = state_reg == sdrc_pkg::SDRC_ISSUE;
  wire [3:0] cmd_next = (issuing & ~blocked) ? order_cmd :
                        sdrc_pkg::CMD_NOP;
  wire cke_next = issuing ? ~(op == sdrc_pkg::OP_SELF |
                              op == sdrc_pkg::OP_PDN) :
                  (state_reg == sdrc_pkg::SDRC_LOWP) ?
                  (state_next == sdrc_pkg::SDRC_WAKE) : 1'b1;
  wire [11:0] a_next = issuing ?
    ((op == sdrc_pkg::OP_ACT) ? addr_reg[11:0] :
     (op == sdrc_pkg::OP_PRE) ? {1'b0, ap_req, 10'h000} :
     {1'b0, ap_ok, 2'b00, col}) :
    {4'h0, beat_col};
  wire wr_beat = (issuing & op == sdrc_pkg::OP_WR) |
                 (state_reg == sdrc_pkg::SDRC_WBEAT & ~go_reg &
                  (full_pg | beat_reg < burst_len));
  // The command cycle carries beat zero, later beats their own index
  wire [8:0] beat_idx = issuing ? 9'h000 : beat_reg;

  // Pin registers: data and enable change with each write beat
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg    <= sdrc_pkg::CMD_NOP;
      cke_reg    <= 1'b1;
      bank_reg   <= 2'b00;
      sdaddr_reg <= 12'h000;
      dqm_reg    <= 2'b11;
      dq_reg     <= 16'h0000;
      oe_reg     <= 1'b0;
    end else begin
      cmd_reg    <= cmd_next;
      cke_reg    <= cke_next;
      bank_reg   <= bank_sel;
      sdaddr_reg <= a_next;
      dqm_reg    <= cfg_reg[sdrc_pkg::CFG_DQM_LSB +: 2];
      dq_reg     <= wdata_reg[15:0] + {7'h00, beat_idx};
      oe_reg     <= wr_beat & ~(issuing & op == sdrc_pkg::OP_RD);
    end
  end

  // Beat counter, wait counter, bank tracking and power-down timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= sdrc_pkg::SDRC_IDLE;
      beat_reg      <= 9'h000;
      wait_reg      <= 8'h00;
      open_reg      <= 4'h0;
      ap_busy_reg   <= 1'b0;
      lowp_cnt_reg  <= 32'h0000_0000;
      busy_reg      <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg  <= state_next != sdrc_pkg::SDRC_IDLE;
      if (issuing) begin
        beat_reg <= (op == sdrc_pkg::OP_RD) ? rd_span : 9'h001;
        wait_reg <= gap_cyc;
        ap_busy_reg <= ap_ok & (op == sdrc_pkg::OP_RD |
                                op == sdrc_pkg::OP_WR);
        if (op == sdrc_pkg::OP_ACT) open_reg[bank_sel] <= 1'b1;
        if (op == sdrc_pkg::OP_PRE) begin
          if (ap_req) open_reg <= 4'h0;
          else        open_reg[bank_sel] <= 1'b0;
        end
      end else if (state_reg == sdrc_pkg::SDRC_WBEAT) begin
        beat_reg <= beat_reg + 9'h001;
      end else if (state_reg == sdrc_pkg::SDRC_RWAIT) begin
        if (beat_reg != 9'h000) beat_reg <= beat_reg - 9'h001;
      end else if (state_reg == sdrc_pkg::SDRC_GAP) begin
        if (wait_reg != 8'h00) wait_reg <= wait_reg - 8'h01;
        if (wait_reg == 8'h01 && ap_busy_reg) begin
          ap_busy_reg        <= 1'b0;
          open_reg[bank_sel] <= 1'b0;
        end
      end
      if (state_reg == sdrc_pkg::SDRC_LOWP)
        lowp_cnt_reg <= lowp_cnt_reg + 32'h0000_0001;
      else
        lowp_cnt_reg <= 32'h0000_0000;
    end
  end

  // Three flops delay read data by a fixed count; beats change every
  // cycle, so the end of a short burst's read window picks its last beat
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d1_reg <= 16'h0000;
      d2_reg <= 16'h0000;
      d3_reg <= 16'h0000;
      rdata_reg <= 32'h0000_0000;
      rd_valid_reg <= 1'b0;
    end else begin
      d1_reg <= sd_dq_in;
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
      if (state_reg == sdrc_pkg::SDRC_RWAIT && rd_due) begin
        rdata_reg    <= {16'h0000, d3_reg};
        rd_valid_reg <= 1'b1;
      end else if (issuing) begin
        rd_valid_reg <= 1'b0;
      end
    end
  end

  assign sd_cs_n   = cmd_reg[3];
  assign sd_ras_n  = cmd_reg[2];
  assign sd_cas_n  = cmd_reg[1];
  assign sd_we_n   = cmd_reg[0];
  assign sd_cke    = cke_reg;
  assign sd_bank   = bank_reg;
  assign sd_addr   = sdaddr_reg;
  assign sd_dqm    = dqm_reg;
  assign sd_dq_out = dq_reg;
  assign sd_dq_oe  = oe_reg;

  // Checks on pin behaviour
  precharge_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_reg == sdrc_pkg::CMD_PRE |=> cmd_reg != sdrc_pkg::CMD_ACT)
    else $error("activate too soon after precharge");
  wake_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cke_reg) |=> cmd_reg == sdrc_pkg::CMD_NOP)
    else $error("no nop after clock gate rise");
  self_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_reg == sdrc_pkg::CMD_REF && !cke_reg) |-> $past(open_reg) == 4'h0)
    else $error("self refresh with open bank");
  fullpage_ap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_reg == sdrc_pkg::CMD_WR && full_pg) |-> !sdaddr_reg[10])
    else $error("auto-precharge in full page");
  stop_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_reg == sdrc_pkg::CMD_BST |-> full_pg)
    else $error("burst stop outside full page");
  read_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_reg == sdrc_pkg::CMD_RD |-> !oe_reg ##1 !oe_reg)
    else $error("bus driven into read");
  ap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ap_busy_reg |-> cmd_reg != sdrc_pkg::CMD_PRE)
    else $error("precharge during auto-precharge");
  lowp_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    lowp_cnt_reg < REFRESH_LIMIT + 2)
    else $error("power-down too long");
  write_cov: cover property (@(posedge pclk) cmd_reg == sdrc_pkg::CMD_WR);
  read_cov: cover property (@(posedge pclk) cmd_reg == sdrc_pkg::CMD_RD);
  lowp_cov: cover property (@(posedge pclk) $rose(cke_reg));
endmodule : sdrc_ctrl

// ==== verilog/sdrc_pkg.sv ====
// Package with command encodings, timing constants and register map
package sdrc_pkg;

  localparam int unsigned CLK_MHZ     = 50;
  localparam int unsigned CLK_PER_NS  = 20;
  // Timing figures in nanoseconds
  localparam int unsigned PRE_NS      = 20;   // precharge_period
  localparam int unsigned WREC_NS     = 7;    // write_recovery_delay
  localparam int unsigned ACTMIN_NS   = 45;
  localparam int unsigned RCD_NS      = 20;
  localparam int unsigned REFRESH_NS  = 64000000;
  // Least times round up, none below one cycle
  localparam int unsigned PRE_CYC =
    (PRE_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int unsigned WREC_CYC =
    (WREC_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int unsigned ACTMIN_CYC =
    (ACTMIN_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int unsigned RCD_CYC =
    (RCD_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int unsigned DATA_ACT_CYC = WREC_CYC + PRE_CYC;
  // Longest stay in power-down rounds down
  localparam int unsigned REFRESH_CYC = REFRESH_NS / CLK_PER_NS;
  localparam int unsigned REFRESH_BURST = 4096;
  // Extra read window cycles while data cross the capture flops
  localparam int unsigned RD_PIPE_CYC = 2;

  // Command pins: chip_select_n, row, column, write strobes
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_RD    = 4'h5;
  localparam logic [3:0] CMD_WR    = 4'h4;
  localparam logic [3:0] CMD_BST   = 4'h6;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_DESEL = 4'hF;

  // Order codes written by software
  localparam logic [2:0] OP_ACT  = 3'h0;
  localparam logic [2:0] OP_RD   = 3'h1;
  localparam logic [2:0] OP_WR   = 3'h2;
  localparam logic [2:0] OP_PRE  = 3'h3;
  localparam logic [2:0] OP_BST  = 3'h4;
  localparam logic [2:0] OP_REF  = 3'h5;
  localparam logic [2:0] OP_SELF = 3'h6;
  localparam logic [2:0] OP_PDN  = 3'h7;

  // Register byte offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CFG    = 8'h14;
  // Field positions
  localparam int unsigned CMD_GO_BIT   = 3;
  localparam int unsigned CMD_AP_BIT   = 4;
  localparam int unsigned CMD_EXIT_BIT = 5;
  localparam int unsigned ADDR_COL_LSB = 0;
  localparam int unsigned ADDR_BANK_LSB = 16;
  localparam int unsigned AP_BIT       = 10;
  localparam logic [31:0] CFG_RESET    = 32'h0000_0022;
  localparam int unsigned CFG_LAT_LSB  = 0;
  localparam int unsigned CFG_LEN_LSB  = 4;
  localparam int unsigned CFG_DQM_LSB  = 8;
  localparam logic [7:0]  FULL_PAGE_LEN = 8'h00;

  typedef enum logic [2:0] {
    SDRC_IDLE  = 3'b000,
    SDRC_ISSUE = 3'b001,
    SDRC_WBEAT = 3'b010,
    SDRC_RWAIT = 3'b011,
    SDRC_GAP   = 3'b100,
    SDRC_LOWP  = 3'b101,
    SDRC_WAKE  = 3'b110
  } sdrc_state_t;

endpackage : sdrc_pkg

// ==== verilog/sdrc_apb_if.sv ====
// Interface carrying decoded register accesses between bus and core
`timescale 1ns/1ps
interface sdrc_apb_if;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  modport slave (output wr_stb, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
  modport core  (input wr_stb, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface : sdrc_apb_if

// ==== verilog/sdrc_apb_slave.sv ====
// APB slave front end: one wait-free access, read data from a register
`timescale 1ns/1ps
module sdrc_apb_slave (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  sdrc_apb_if.slave        regs
);
  logic [31:0] prdata_reg;
  wire         access = psel & penable;

  // Every access completes in its first access cycle
  assign pready       = 1'b1;
  assign pslverr      = 1'b0;
  assign regs.wr_stb  = access & pwrite;
  assign regs.wr_addr = paddr;
  assign regs.wr_data = pwdata;
  assign regs.rd_addr = paddr;
  assign prdata       = prdata_reg;

  // Capture read data during setup so it is stable in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_reg <= regs.rd_data;
    end
  end
endmodule : sdrc_apb_slave

// ==== sim/sdrc_sdram_model.sv ====
// Behavioural SDRAM partner: short bursts on the open row
`timescale 1ns/1ps
module sdrc_sdram_model #(
  parameter int unsigned BURST_LEN = 2,
  parameter int unsigned LAT = 2
) (
  input  wire logic        pclk,
  input  wire logic [3:0]  cmd,
  input  wire logic        cke,
  input  wire logic [11:0] addr,
  input  wire logic [1:0]  dqm,
  input  wire logic        dq_oe,
  input  wire logic [15:0] dq_w,
  output logic [15:0]      dq_r
);
  logic [15:0] mem [256];
  logic [7:0]  wcol = 8'h00;
  logic [7:0]  rcol = 8'h00;
  int          wleft = 0;
  int          rleft = 0;
  logic [16:0] pipe [LAT] = '{default: 17'h00000};
  logic [15:0] last = 16'h0000;
  // Column step, no carry out of the aligned block
  function automatic logic [7:0] step(input logic [7:0] c);
    // Two-beat interleave order is the same as sequential order
    return (c & ~8'(BURST_LEN - 1))
           | ((c + 8'h01) & 8'(BURST_LEN - 1));
  endfunction : step
  // Gated clock freezes all; NOP and deselect keep bursts going
  always @(posedge pclk) begin
    if (cke) begin
      if (cmd == sdrc_pkg::CMD_WR) begin
        wleft = BURST_LEN;
        wcol  = addr[7:0];
      end else if (!(cmd == sdrc_pkg::CMD_NOP || cmd[3]))
        wleft = 0;
      if (wleft > 0) begin
        if (dq_oe && dqm == 2'h0) mem[wcol] = dq_w;
        wcol  = step(wcol);
        wleft = wleft - 1;
      end
      if (cmd == sdrc_pkg::CMD_RD) begin
        rleft = BURST_LEN;
        rcol  = addr[7:0];
      end else if (cmd == sdrc_pkg::CMD_BST || cmd == sdrc_pkg::CMD_PRE)
        rleft = 0;
      for (int i = LAT - 1; i > 0; i--) pipe[i] = pipe[i - 1];
      pipe[0] = {rleft > 0, mem[rcol]};
      if (rleft > 0) begin
        rcol  = step(rcol);
        rleft = rleft - 1;
      end
      if (pipe[LAT - 1][16]) last = pipe[LAT - 1][15:0];
      // Released bus shows the inverse of the last beat, not a stale copy;
      // non-blocking so the controller samples it free of races
      dq_r <= pipe[LAT - 1][16] ? pipe[LAT - 1][15:0] : ~last;
    end
  end
endmodule : sdrc_sdram_model

// ==== sim/sdrc_ctrl_test.sv ====
// Self-checking bench for the SDRAM command controller
`timescale 1ns/1ps
module sdrc_ctrl_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n;
  logic        sd_cke, sd_dq_oe;
  logic [1:0]  sd_bank, sd_dqm;
  logic [11:0] sd_addr;
  logic [15:0] sd_dq_out, sd_dq_in;
  wire  [3:0]  pins = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  sdrc_ctrl #(.REFRESH_LIMIT(50)) u_sdrc_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sd_cs_n(sd_cs_n),
    .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n),
    .sd_cke(sd_cke), .sd_bank(sd_bank), .sd_addr(sd_addr),
    .sd_dqm(sd_dqm), .sd_dq_out(sd_dq_out), .sd_dq_oe(sd_dq_oe),
    .sd_dq_in(sd_dq_in));
  sdrc_sdram_model u_sdrc_sdram_model (
    .pclk(pclk), .cmd(pins), .cke(sd_cke), .addr(sd_addr), .dqm(sd_dqm),
    .dq_oe(sd_dq_oe), .dq_w(sd_dq_out), .dq_r(sd_dq_in));
  // Clock, and a cycle ceiling that cuts a hang short
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      test_done();
    end
  end
  task automatic test_done();
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk
  // One APB transfer, held until pready is seen high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits for go, busy and auto-precharge busy to clear
  task automatic idle();
    rd = 32'h0000_0083;
    for (int n = 0; n < 60 && (rd & 32'h83) !== 32'h0; n++)
      apb(1'b0, sdrc_pkg::REG_STATUS, 32'h0);
  endtask : idle
  task automatic await(logic [3:0] e);
    @(negedge pclk);
    for (int n = 0; n < 40 && pins !== e; n++) @(negedge pclk);
    chk("command", 32'(e), 32'(pins));
  endtask : await
  task automatic order(logic [2:0] op, logic [31:0] f, logic [3:0] e);
    idle();
    apb(1'b1, sdrc_pkg::REG_CMD, f | 32'(op) | 32'h8);
    await(e);
  endtask : order
  task automatic t_reset();
    chk("reset cmd", 32'(sdrc_pkg::CMD_NOP), 32'(pins));
    chk("reset pins", 32'hE, {28'h0, sd_cke, sd_dqm, sd_dq_oe});
    presetn <= 1'b1;
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("slverr", 32'h0, 32'(pslverr));
    apb(1'b0, sdrc_pkg::REG_CFG, 32'h0);
    chk("cfg", sdrc_pkg::CFG_RESET, rd);
  endtask : t_reset
  task automatic t_write_read();
    apb(1'b1, sdrc_pkg::REG_ADDR, 32'h0001_0123);
    order(sdrc_pkg::OP_ACT, 32'h0, sdrc_pkg::CMD_ACT);
    chk("row", 32'h0001_0123, {14'h0, sd_bank, 4'h0, sd_addr});
    apb(1'b1, sdrc_pkg::REG_ADDR, 32'h0001_0001);
    apb(1'b1, sdrc_pkg::REG_WDATA, 32'h0000_A5A0);
    order(sdrc_pkg::OP_WR, 32'h0, sdrc_pkg::CMD_WR);
    chk("beat0", 32'h0001_A5A0, {15'h0, sd_dq_oe, sd_dq_out});
    @(negedge pclk);
    chk("beat1", 32'h0001_A5A1, {15'h0, sd_dq_oe, sd_dq_out});
    apb(1'b1, sdrc_pkg::REG_ADDR, 32'h0001_0000);
    order(sdrc_pkg::OP_RD, 32'h0, sdrc_pkg::CMD_RD);
    chk("bus free", 32'h0, 32'(sd_dq_oe));
    rd = 32'h0;
    for (int n = 0; n < 20 && rd[2] !== 1'b1; n++)
      apb(1'b0, sdrc_pkg::REG_STATUS, 32'h0);
    apb(1'b0, sdrc_pkg::REG_RDATA, 32'h0);
    chk("rdata", 32'h0000_A5A0, rd & 32'hFFFF);
  endtask : t_write_read
  task automatic t_precharge();
    order(sdrc_pkg::OP_WR, 32'h10, sdrc_pkg::CMD_WR);
    chk("ap bit", 32'h1, 32'(sd_addr[10]));
    order(sdrc_pkg::OP_ACT, 32'h0, sdrc_pkg::CMD_ACT);
    order(sdrc_pkg::OP_PRE, 32'h0, sdrc_pkg::CMD_PRE);
    chk("pre one", 32'h2, {29'h0, sd_bank, sd_addr[10]});
    order(sdrc_pkg::OP_PRE, 32'h10, sdrc_pkg::CMD_PRE);
    chk("pre all", 32'h1, 32'(sd_addr[10]));
    order(sdrc_pkg::OP_REF, 32'h0, sdrc_pkg::CMD_REF);
    chk("ref cke", 32'h1, 32'(sd_cke));
  endtask : t_precharge
  // Self refresh leaves on order; power-down must leave by itself
  task automatic t_lowp(logic [2:0] op, logic self);
    idle();
    apb(1'b1, sdrc_pkg::REG_CMD, 32'(op) | 32'h8);
    for (int n = 0; n < 40 && sd_cke !== 1'b0; n++) @(negedge pclk);
    if (self) chk("sr entry", 32'(sdrc_pkg::CMD_REF), 32'(pins));
    repeat (20) @(negedge pclk);
    chk("cke held", 32'h0, 32'(sd_cke));
    if (self) apb(1'b1, sdrc_pkg::REG_CMD, 32'h20);
    for (int n = 0; n < 80 && sd_cke !== 1'b1; n++) @(negedge pclk);
    chk("woken", 32'h1, 32'(sd_cke));
    repeat (2) begin
      chk("wake nop", 32'h1, 32'(pins === 4'h7 || pins[3] === 1'b1));
      @(negedge pclk);
    end
  endtask : t_lowp
  task automatic t_stop();
    apb(1'b1, sdrc_pkg::REG_CFG, 32'h0000_0002);
    order(sdrc_pkg::OP_ACT, 32'h0, sdrc_pkg::CMD_ACT);
    order(sdrc_pkg::OP_RD, 32'h0, sdrc_pkg::CMD_RD);
    apb(1'b1, sdrc_pkg::REG_CMD, 32'(sdrc_pkg::OP_BST) | 32'h8);
    await(sdrc_pkg::CMD_BST);
    order(sdrc_pkg::OP_WR, 32'h10, sdrc_pkg::CMD_WR);
    chk("page ap", 32'h0, 32'(sd_addr[10]));
    apb(1'b1, sdrc_pkg::REG_CMD, 32'(sdrc_pkg::OP_BST) | 32'h8);
    await(sdrc_pkg::CMD_BST);
    chk("page end", 32'h0, 32'(sd_dq_oe));
    order(sdrc_pkg::OP_PRE, 32'h10, sdrc_pkg::CMD_PRE);
  endtask : t_stop
  initial begin
    repeat (4) @(posedge pclk);
    t_reset();
    t_write_read();
    t_precharge();
    t_lowp(sdrc_pkg::OP_SELF, 1'b1);
    t_lowp(sdrc_pkg::OP_PDN, 1'b0);
    t_stop();
    test_done();
  end
endmodule : sdrc_ctrl_test
